/* rie_dec_if.sv */
// decode results passed from the opcode decoder to the execution unit
`timescale 1ns/1ps
`default_nettype none
interface rie_dec_if;
    logic [13:0] instr;       // instruction word to decode
    logic        is_iret;     // interrupt return decoded
    logic        is_lret;     // literal return decoded
    logic        is_ret;      // subroutine return decoded
    logic [7:0]  literal;     // immediate of a literal return

    // decoder side
    modport decoder (
        input  instr,
        output is_iret,
        output is_lret,
        output is_ret,
        output literal
    );
    // execution side
    modport exec (
        output instr,
        input  is_iret,
        input  is_lret,
        input  is_ret,
        input  literal
    );
endinterface
`default_nettype wire

/* rie_decode.sv */
// combinational decoder for the three return opcodes
`timescale 1ns/1ps
`default_nettype none
module rie_decode (
    rie_dec_if.decoder dec
);
    // exact match for the two operand-less returns
    assign dec.is_iret = (dec.instr == rie_pkg::OP_IRET);
    assign dec.is_ret  = (dec.instr == rie_pkg::OP_RET);
    // masked match, bits 9:8 ignored
    assign dec.is_lret = ((dec.instr & rie_pkg::LRET_MASK) == rie_pkg::LRET_MATCH);
    // low eight bits carry the literal, any value 0..255
    assign dec.literal = dec.instr[rie_pkg::LIT_LSB +: rie_pkg::DATA_W];
endmodule
`default_nettype wire

/* rie_pkg.sv */
// constants shared by the return instruction execution unit
package rie_pkg;
    // instruction word, program counter and data widths
    localparam int          INSTR_W    = 14;
    localparam int          PC_W       = 13;
    localparam int          DATA_W     = 8;
    // interrupt return opcode, exact match
    localparam logic [13:0] OP_IRET    = 14'h0009;
    // subroutine return opcode, exact match
    localparam logic [13:0] OP_RET     = 14'h0008;
    // literal return: bits 13:10 must match, bits 9:8 are don't care
    localparam logic [13:0] LRET_MASK  = 14'h3c00;
    localparam logic [13:0] LRET_MATCH = 14'h3400;
    // literal field position
    localparam int          LIT_LSB    = 0;
    // global interrupt enable position inside the interrupt control register
    localparam int          IRQ_EN_BIT = 7;
    // instruction cycles taken by every return
    localparam int          RET_CYCLES = 2;
    // reset values
    localparam logic [12:0] PC_RST     = 13'h0000;
    localparam logic [7:0]  W_RST      = 8'h00;
    localparam logic [7:0]  IRQC_RST   = 8'h00;
endpackage

/* rie_return_exec.sv */
// execution unit for interrupt return, literal return and subroutine return
`timescale 1ns/1ps
`default_nettype none
module rie_return_exec (
    input  wire logic        clk,              // 250 MHz core clock
    input  wire logic        rstn,             // synchronous reset, active low
    input  wire logic        instr_valid,      // fetched word present this cycle
    input  wire logic [13:0] instr,            // fetched instruction word
    input  wire logic [12:0] stack_top,        // current top of return stack
    input  wire logic        w_wr_en,          // other instructions writing W
    input  wire logic [7:0]  w_wr_data,        // data for that W write
    input  wire logic        ctl_wr_en,        // other writes to interrupt control
    input  wire logic [7:0]  ctl_wr_data,      // data for that control write
    output logic      [12:0] pc,               // program counter
    output logic      [7:0]  w_reg,            // working register
    output logic      [7:0]  irq_control_reg,  // interrupt control register
    output logic             stack_pop,        // one-cycle pop strobe to stack
    output logic             prefetch_flush    // prefetched word is discarded
);
    // execution phase
    typedef enum logic {
        ST_EXEC,
        ST_FLUSH
    } rie_state_e;

    rie_state_e  state;       // current phase
    logic        take_ret;    // a return is accepted this cycle
    logic        any_ret;     // decoded word is one of the returns

    // decode carrier
    rie_dec_if dec ();

    // opcode decoder
    rie_decode u_decode (
        .dec (dec)
    );

    // word under decode
    assign dec.instr = instr;
    // any of the three returns
    assign any_ret   = dec.is_iret | dec.is_lret | dec.is_ret;
    // a return is only taken in the execute phase, never on a discarded word
    assign take_ret  = (state == ST_EXEC) && instr_valid && any_ret;

    // phase sequencing: return takes execute plus one flush cycle
    // two cycle sequence
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= ST_EXEC;
        end else begin
            case (state)
                // accept the return, go to the refetch cycle
                ST_EXEC: begin
                    if (take_ret) begin
                        state <= ST_FLUSH;
                    end
                end
                // refetch cycle always returns to execute
                ST_FLUSH: begin
                    state <= ST_EXEC;
                end
                default: begin
                    state <= ST_EXEC;
                end
            endcase
        end
    end

    // program counter: restored from stack top on any return
    // stack top into pc
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pc <= rie_pkg::PC_RST;
        end else if (take_ret) begin
            pc <= stack_top;
        end else if ((state == ST_EXEC) && instr_valid) begin
            // sequential fetch for any other instruction
            pc <= pc + 13'h0001;
        end
    end

    // pop strobe: one cycle, in the refetch cycle
    // stack pop strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stack_pop <= 1'b0;
        end else begin
            stack_pop <= take_ret;
        end
    end

    // flush flag marks the second cycle, fetched word is ignored
    // discard prefetched word
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prefetch_flush <= 1'b0;
        end else begin
            prefetch_flush <= take_ret;
        end
    end

    // working register: literal return overrides other writers
    // literal into W
    always_ff @(posedge clk) begin
        if (!rstn) begin
            w_reg <= rie_pkg::W_RST;
        end else if (take_ret && dec.is_lret) begin
            // full 8-bit literal, don't care bits dropped
            // every literal accepted
            w_reg <= dec.literal;
        end else if (w_wr_en) begin
            // ordinary write from the rest of the core
            w_reg <= w_wr_data;
        end
    end

    // interrupt control: iret sets enable, set wins over a clearing write
    // set global enable
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_control_reg <= rie_pkg::IRQC_RST;
        end else begin
            if (ctl_wr_en) begin
                irq_control_reg <= ctl_wr_data;
            end
            if (take_ret && dec.is_iret) begin
                irq_control_reg[rie_pkg::IRQ_EN_BIT] <= 1'b1;
            end
        end
    end

    // checks on the return sequencing
    // all checks are cut off while reset is low, so a return caught
    // by a mid-run reset is not judged against a stale past value
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_iret_pc_pop: assert property (
        take_ret && dec.is_iret |=> (pc == $past(stack_top)) && stack_pop
    ) else $error("interrupt return did not pop stack into pc");

    a_iret_enable_set: assert property (
        take_ret && dec.is_iret |=> irq_control_reg[rie_pkg::IRQ_EN_BIT]
    ) else $error("interrupt return did not set global enable");

    a_ret_two_cycles: assert property (
        take_ret |=> (state == ST_FLUSH) && !take_ret ##1 (state == ST_EXEC)
    ) else $error("return did not take exactly two cycles");

    a_lret_w_load: assert property (
        take_ret && dec.is_lret |=> (w_reg == $past(instr[7:0])) && (pc == $past(stack_top))
    ) else $error("literal return did not load W and pc");

    a_lret_any_lit: assert property (
        instr_valid && (instr[13:10] == 4'hd) |-> dec.is_lret && (dec.literal == instr[7:0])
    ) else $error("literal return not decoded for this literal");

    a_ret_ctl_kept: assert property (
        take_ret && dec.is_ret && !ctl_wr_en
            |=> (irq_control_reg == $past(irq_control_reg)) && (pc == $past(stack_top))
    ) else $error("subroutine return altered control or missed pc");

    a_flush_holds_pc: assert property (
        state == ST_FLUSH |-> prefetch_flush ##1 (pc == $past(pc)) && !stack_pop
    ) else $error("prefetched word was not discarded");

    a_pop_one_cycle: assert property (
        stack_pop |=> !stack_pop
    ) else $error("pop strobe lasted more than one cycle");

    a_ret_pc_restore: assert property (
        take_ret |=> (pc == $past(stack_top))
    ) else $error("return did not restore pc from stack top");

    a_no_ret_quiet: assert property (
        !take_ret |=> !stack_pop && !prefetch_flush
    ) else $error("pop or flush strobe without a return");

    a_nonret_pc_step: assert property (
        (state == ST_EXEC) && instr_valid && !any_ret |=> (pc == $past(pc) + 13'h0001)
    ) else $error("ordinary word did not advance pc by one");

    a_iret_w_kept: assert property (
        take_ret && dec.is_iret && !w_wr_en |=> (w_reg == $past(w_reg))
    ) else $error("interrupt return altered the working register");

    a_lret_ctl_kept: assert property (
        take_ret && dec.is_lret && !ctl_wr_en |=> (irq_control_reg == $past(irq_control_reg))
    ) else $error("literal return altered the control register");

    a_ret_w_kept: assert property (
        take_ret && dec.is_ret && !w_wr_en |=> (w_reg == $past(w_reg))
    ) else $error("subroutine return altered the working register");

    a_flush_one_cycle: assert property (
        prefetch_flush |=> !prefetch_flush
    ) else $error("flush strobe lasted more than one cycle");

    a_flush_no_take: assert property (
        prefetch_flush |-> !take_ret
    ) else $error("word decoded during the flush cycle");

    a_flush_pop_pair: assert property (
        prefetch_flush |-> stack_pop
    ) else $error("flush cycle without a pop strobe");

    a_idle_pc_hold: assert property (
        !instr_valid |=> (pc == $past(pc))
    ) else $error("pc moved without a fetched word");

    a_exec_after_flush: assert property (
        (state == ST_FLUSH) |=> (state == ST_EXEC)
    ) else $error("flush cycle did not return to execute");

endmodule
`default_nettype wire

/* rie_return_exec_test.sv */
// self-checking testbench for the return instruction execution unit
`timescale 1ns/1ps
`default_nettype none
module rie_return_exec_test;
    logic        clk;              // core clock, 4 ns period
    logic        rstn;             // synchronous reset, active low
    logic        instr_valid;      // fetched word present
    logic [13:0] instr;            // fetched word
    logic [12:0] stack_top;        // return address on the stack
    logic        w_wr_en;          // competing working register write
    logic [7:0]  w_wr_data;        // data of that write
    logic        ctl_wr_en;        // competing control register write
    logic [7:0]  ctl_wr_data;      // data of that write
    logic [12:0] pc;               // observed program counter
    logic [7:0]  w_reg;            // observed working register
    logic [7:0]  irq_control_reg;  // observed interrupt control
    logic        stack_pop;        // observed pop strobe
    logic        prefetch_flush;   // observed flush strobe
    logic [12:0] e_pc;             // expected program counter
    logic [7:0]  e_w;              // expected working register
    logic [7:0]  e_c;              // expected control register
    logic        e_pop;            // expected pop strobe
    logic        e_fl;             // expected flush strobe
    logic [31:0] r;                // random scratch
    int          seed;             // fixed seed
    int          n_fail;           // mismatches
    int          check_count;      // comparisons
    int          i;                // loop index

    rie_return_exec dut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
        .stack_top(stack_top), .w_wr_en(w_wr_en), .w_wr_data(w_wr_data), .ctl_wr_en(ctl_wr_en),
        .ctl_wr_data(ctl_wr_data), .pc(pc), .w_reg(w_reg), .irq_control_reg(irq_control_reg),
        .stack_pop(stack_pop), .prefetch_flush(prefetch_flush));

    // free running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // return kind: 1 interrupt, 2 literal, 3 subroutine, 0 none
    function automatic logic [1:0] kind(input logic [13:0] v);
        if (v === rie_pkg::OP_IRET) return 2'h1;
        if ((v & rie_pkg::LRET_MASK) === rie_pkg::LRET_MATCH) return 2'h2;
        if (v === rie_pkg::OP_RET) return 2'h3;
        return 2'h0;
    endfunction

    // compare one value and count it
    task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // reference model, one rising edge
    task automatic model();
        if (!rstn) begin
            e_pc = rie_pkg::PC_RST;
            e_w = rie_pkg::W_RST;
            e_c = rie_pkg::IRQC_RST;
            e_pop = 1'b0;
            e_fl = 1'b0;
        end else begin
            if (w_wr_en) e_w = w_wr_data;
            if (ctl_wr_en) e_c = ctl_wr_data;
            if (e_fl) begin
                e_pop = 1'b0;
                e_fl = 1'b0;
            end else if (instr_valid && kind(instr) != 2'h0) begin
                e_pc = stack_top;
                e_pop = 1'b1;
                e_fl = 1'b1;
                if (kind(instr) == 2'h2) e_w = instr[7:0];
                if (kind(instr) == 2'h1) e_c[rie_pkg::IRQ_EN_BIT] = 1'b1;
            end else begin
                e_pop = 1'b0;
                e_fl = 1'b0;
                if (instr_valid) e_pc = e_pc + 13'h0001;
            end
        end
    endtask

    // drive at the falling edge, check at the next falling edge
    task automatic cyc(input logic v, input logic [13:0] ins, input logic we, input logic ce);
        instr_valid = v;
        instr = ins;
        r = $random(seed);
        stack_top = r[12:0];
        w_wr_data = r[20:13];
        ctl_wr_data = r[31:24];
        w_wr_en = we;
        ctl_wr_en = ce;
        @(posedge clk);
        model();
        @(negedge clk);
        cmp(pc, e_pc);
        cmp({5'h00, w_reg}, {5'h00, e_w});
        cmp({5'h00, irq_control_reg}, {5'h00, e_c});
        cmp({12'h000, stack_pop}, {12'h000, e_pop});
        cmp({12'h000, prefetch_flush}, {12'h000, e_fl});
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        seed = 17;
        n_fail = 0;
        check_count = 0;
        rstn = 1'b0;
        @(negedge clk);
        for (i = 0; i < 8; i++) cyc(1'b0, 14'h0000, 1'b0, 1'b0);
        rstn = 1'b1;
        // literal returns over all don't care codes, extreme literals, return word in flush cycle
        for (i = 0; i < 4; i++) begin
            cyc(1'b1, {4'hd, i[1:0], i[0] ? 8'hff : 8'h00}, 1'b1, 1'b0);
            cyc(1'b1, rie_pkg::OP_IRET, 1'b0, 1'b0);
        end
        cyc(1'b1, rie_pkg::OP_IRET, 1'b0, 1'b1);
        cyc(1'b1, rie_pkg::OP_RET, 1'b1, 1'b1);
        cyc(1'b1, rie_pkg::OP_RET, 1'b0, 1'b0);
        cyc(1'b1, 14'h0123, 1'b0, 1'b0);
        cyc(1'b1, 14'h0456, 1'b0, 1'b0);
        // random traffic with a reset in mid run
        for (i = 0; i < 3000; i++) begin
            rstn = (i < 1500 || i > 1502);
            r = $random(seed);
            cyc(r[0], r[3:1] == 3'h0 ? rie_pkg::OP_IRET : r[3:1] == 3'h1 ? rie_pkg::OP_RET :
                r[3:1] == 3'h2 ? {4'hd, r[31:22]} : r[17:4], r[19:18] == 2'h0, r[21:20] == 2'h0);
        end
        conclude();
    end
endmodule
`default_nettype wire
